// File: hw/fpl_pkg.sv
package fpl_pkg;

  // clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int SELF_RESET_S = 3;
  localparam int SELF_RESET_CYCLES = CLK_HZ * SELF_RESET_S;
  localparam int FLASH_HALF_MS = 500;
  localparam int FLASH_HALF_CYCLES = (CLK_HZ / 1000) * FLASH_HALF_MS;
  localparam int SELF_RESET_CNT_W = 27;
  localparam int FLASH_CNT_W = 25;

  // internal signal bus layout
  localparam int BUS_W = 256;
  localparam int PROG_LED_N = 8;
  localparam int FKEY_LED_N = 10;
  localparam int PROG_ORD_BASE = 192;
  localparam int FKEY_ORD_BASE = PROG_ORD_BASE + 2 * PROG_LED_N;

  // link bit position that enables trip self-reset
  localparam int LINK_W = 16;
  localparam int LINK_SELF_RESET_BIT = 0;

  // alarm lamp states
  typedef enum logic [1:0] {
    ALM_OFF = 2'b00,
    ALM_FLASH = 2'b01,
    ALM_STEADY = 2'b10
  } fpl_alarm_state_t;

  // ordinal of red drive of lamp i, green is the next one
  function automatic int fpl_red_ord(input int base, input int i);
    return base + 2 * i;
  endfunction : fpl_red_ord

  function automatic int fpl_grn_ord(input int base, input int i);
    return base + 2 * i + 1;
  endfunction : fpl_grn_ord

endpackage : fpl_pkg

// File: hw/fpl_trip_latch.sv
`timescale 1ns/10ps
`default_nettype none
module fpl_trip_latch #(
  parameter int SELF_RESET_CYCLES = fpl_pkg::SELF_RESET_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic trip_in,
  input wire logic manual_clear,
  input wire logic self_reset_en,
  input wire logic breaker_closed,
  input wire logic any_pole_dead,
  input wire logic any_start,
  output logic trip_lit
);
  import fpl_pkg::*;

  localparam logic [SELF_RESET_CNT_W-1:0] SR_LAST = SELF_RESET_CNT_W'(SELF_RESET_CYCLES - 1);

  logic lit_q, lit_d;
  logic inhibit_q, inhibit_d;
  logic [SELF_RESET_CNT_W-1:0] cnt_q, cnt_d;
  logic self_clear;
  logic dwell_ok;

  // self-reset dwell timer and start inhibit
  always_comb begin
    inhibit_d = inhibit_q;
    cnt_d = cnt_q;
    self_clear = 1'b0;
    if (!breaker_closed || !lit_q) begin
      inhibit_d = 1'b0; // re-armed by the next reclose
    end else if (any_start) begin
      inhibit_d = 1'b1;
    end
    dwell_ok = self_reset_en && lit_q && breaker_closed && !any_pole_dead && !any_start
               && !inhibit_q && !trip_in;
    if (!dwell_ok) begin
      cnt_d = '0; // any break restarts the full dwell
    end else if (cnt_q == SR_LAST) begin
      cnt_d = '0;
      self_clear = 1'b1;
    end else begin
      cnt_d = cnt_q + SELF_RESET_CNT_W'(1);
    end
  end

  // lamp latch, a fresh trip beats any clear in the same cycle
  always_comb begin
    lit_d = lit_q;
    if (trip_in) begin
      lit_d = 1'b1;
    end else if (manual_clear || self_clear) begin
      lit_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      lit_q <= 1'b0;
      inhibit_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      lit_q <= lit_d;
      inhibit_q <= inhibit_d;
      cnt_q <= cnt_d;
    end
  end

  assign trip_lit = lit_q;

endmodule : fpl_trip_latch
`default_nettype wire

// File: hw/fpl_panel_leds.sv
`timescale 1ns/10ps
`default_nettype none
module fpl_panel_leds #(
  parameter int SELF_RESET_CYCLES = fpl_pkg::SELF_RESET_CYCLES,
  parameter int FLASH_HALF_CYCLES = fpl_pkg::FLASH_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  // protection trip output
  input wire logic trip_out,
  // fault record tied to the trip was cleared, one-cycle pulse
  input wire logic fault_record_cleared,
  // clear key level, acts on the press
  input wire logic clear_key,
  // reset logic input, acts on assertion
  input wire logic reset_logic_input,
  input wire logic [fpl_pkg::LINK_W-1:0] system_function_link_bits,
  input wire logic breaker_closed,
  input wire logic any_pole_dead,
  input wire logic any_start,
  // record arrivals, one-cycle pulses
  input wire logic new_fault_record,
  input wire logic new_event_record,
  input wire logic new_maint_record,
  input wire logic alarms_read,
  input wire logic alarms_cleared,
  input wire logic protection_unavailable,
  input wire logic selftest_fault,
  input wire logic [fpl_pkg::BUS_W-1:0] internal_signal_bus,
  output logic trip_lamp,
  output logic alarm_lamp,
  output logic out_of_service_lamp,
  output logic healthy_lamp,
  output logic watchdog_contact,
  output logic [fpl_pkg::PROG_LED_N-1:0] prog_red_drive,
  output logic [fpl_pkg::PROG_LED_N-1:0] prog_green_drive,
  output logic [fpl_pkg::FKEY_LED_N-1:0] fkey_red_drive,
  output logic [fpl_pkg::FKEY_LED_N-1:0] fkey_green_drive
);
  import fpl_pkg::*;

  localparam logic [FLASH_CNT_W-1:0] FLASH_LAST = FLASH_CNT_W'(FLASH_HALF_CYCLES - 1);

  // input edge history
  logic clear_key_q, clear_key_d;
  logic rst_in_q, rst_in_d;
  logic manual_clear;
  logic trip_lit;

  // alarm lamp state
  fpl_alarm_state_t alm_q, alm_d;
  logic [FLASH_CNT_W-1:0] flash_cnt_q, flash_cnt_d;
  logic flash_phase_q, flash_phase_d;
  logic new_alarm;

  // lamp registers
  logic trip_lamp_q, trip_lamp_d;
  logic alarm_lamp_q, alarm_lamp_d;
  logic oos_q, oos_d;
  logic healthy_q, healthy_d;
  logic watchdog_q, watchdog_d;
  logic [PROG_LED_N-1:0] prog_red_q, prog_red_d;
  logic [PROG_LED_N-1:0] prog_grn_q, prog_grn_d;
  logic [FKEY_LED_N-1:0] fkey_red_q, fkey_red_d;
  logic [FKEY_LED_N-1:0] fkey_grn_q, fkey_grn_d;

  // edge detect on clear key and reset input
  always_comb begin
    clear_key_d = clear_key;
    rst_in_d = reset_logic_input;
    manual_clear = (clear_key && !clear_key_q) || (reset_logic_input && !rst_in_q)
                   || fault_record_cleared;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      clear_key_q <= 1'b0;
      rst_in_q <= 1'b0;
    end else begin
      clear_key_q <= clear_key_d;
      rst_in_q <= rst_in_d;
    end
  end

  // trip latch with self-reset timer
  fpl_trip_latch #(
    .SELF_RESET_CYCLES(SELF_RESET_CYCLES)
  ) u_trip_latch (
    .clk(clk),
    .reset(reset),
    .trip_in(trip_out),
    .manual_clear(manual_clear),
    .self_reset_en(system_function_link_bits[LINK_SELF_RESET_BIT]),
    .breaker_closed(breaker_closed),
    .any_pole_dead(any_pole_dead),
    .any_start(any_start),
    .trip_lit(trip_lit)
  );

  // alarm lamp sequencing
  always_comb begin
    alm_d = alm_q;
    new_alarm = new_fault_record || new_event_record || new_maint_record;
    case (alm_q)
      ALM_OFF: begin
        if (new_alarm) begin
          alm_d = ALM_FLASH;
        end
      end
      ALM_FLASH: begin
        if (new_alarm) begin
          alm_d = ALM_FLASH; // fresh alarm wins over read or clear
        end else if (alarms_cleared) begin
          alm_d = ALM_OFF;
        end else if (alarms_read) begin
          alm_d = ALM_STEADY;
        end
      end
      ALM_STEADY: begin
        if (new_alarm) begin
          alm_d = ALM_FLASH;
        end else if (alarms_cleared) begin
          alm_d = ALM_OFF;
        end
      end
      default: begin
        alm_d = ALM_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      alm_q <= ALM_OFF;
    end else begin
      alm_q <= alm_d;
    end
  end

  // flash cadence, free running only while flashing
  always_comb begin
    flash_cnt_d = flash_cnt_q;
    flash_phase_d = flash_phase_q;
    if (alm_d != ALM_FLASH) begin
      // restart so a new alarm always opens with the lamp lit
      flash_cnt_d = '0;
      flash_phase_d = 1'b1;
    end else if (alm_q != ALM_FLASH || new_alarm) begin
      // a fresh alarm while flashing also reopens lit, so it is never missed
      flash_cnt_d = '0;
      flash_phase_d = 1'b1;
    end else if (flash_cnt_q == FLASH_LAST) begin
      flash_cnt_d = '0;
      flash_phase_d = !flash_phase_q;
    end else begin
      flash_cnt_d = flash_cnt_q + FLASH_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flash_cnt_q <= '0;
      flash_phase_q <= 1'b1;
    end else begin
      flash_cnt_q <= flash_cnt_d;
      flash_phase_q <= flash_phase_d;
    end
  end

  // fixed-function lamps
  always_comb begin
    trip_lamp_d = trip_lit;
    case (alm_q)
      ALM_FLASH: alarm_lamp_d = flash_phase_q;
      ALM_STEADY: alarm_lamp_d = 1'b1;
      default: alarm_lamp_d = 1'b0;
    endcase
    oos_d = protection_unavailable;
    healthy_d = !selftest_fault;
    watchdog_d = healthy_d; // same next value, so both flip on one edge
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trip_lamp_q <= 1'b0;
      alarm_lamp_q <= 1'b0;
      oos_q <= 1'b0;
      healthy_q <= 1'b0;
      watchdog_q <= 1'b0;
    end else begin
      trip_lamp_q <= trip_lamp_d;
      alarm_lamp_q <= alarm_lamp_d;
      oos_q <= oos_d;
      healthy_q <= healthy_d;
      watchdog_q <= watchdog_d;
    end
  end

  // tri-colour drives picked off the internal signal bus
  // consecutive ordinal pairs
  for (genvar i = 0; i < PROG_LED_N; i++) begin : g_prog
    always_comb begin
      prog_red_d[i] = internal_signal_bus[fpl_red_ord(PROG_ORD_BASE, i)];
      prog_grn_d[i] = internal_signal_bus[fpl_grn_ord(PROG_ORD_BASE, i)];
    end
  end

  // function key lamps follow the same pairing after the programmable ones
  // scheme ties key lamps
  for (genvar k = 0; k < FKEY_LED_N; k++) begin : g_fkey
    always_comb begin
      fkey_red_d[k] = internal_signal_bus[fpl_red_ord(FKEY_ORD_BASE, k)];
      fkey_grn_d[k] = internal_signal_bus[fpl_grn_ord(FKEY_ORD_BASE, k)];
    end
  end

  // one edge of latency keeps every lamp pin on a flip-flop
  always_ff @(posedge clk) begin
    if (reset) begin
      prog_red_q <= '0;
      prog_grn_q <= '0;
      fkey_red_q <= '0;
      fkey_grn_q <= '0;
    end else begin
      prog_red_q <= prog_red_d;
      prog_grn_q <= prog_grn_d;
      fkey_red_q <= fkey_red_d;
      fkey_grn_q <= fkey_grn_d;
    end
  end

  // outputs
  assign trip_lamp = trip_lamp_q;
  assign alarm_lamp = alarm_lamp_q;
  assign out_of_service_lamp = oos_q;
  assign healthy_lamp = healthy_q;
  assign watchdog_contact = watchdog_q;
  assign prog_red_drive = prog_red_q;
  assign prog_green_drive = prog_grn_q;
  assign fkey_red_drive = fkey_red_q;
  assign fkey_green_drive = fkey_grn_q;

endmodule : fpl_panel_leds
`default_nettype wire

// File: verif/fpl_panel_leds_properties.sv
`timescale 1ns/10ps
`default_nettype none
module fpl_panel_leds_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic trip_out,
  input wire logic fault_record_cleared,
  input wire logic clear_key,
  input wire logic reset_logic_input,
  input wire logic new_fault_record,
  input wire logic new_event_record,
  input wire logic new_maint_record,
  input wire logic alarms_cleared,
  input wire logic protection_unavailable,
  input wire logic selftest_fault,
  input wire logic [fpl_pkg::BUS_W-1:0] internal_signal_bus,
  input wire logic trip_lamp,
  input wire logic alarm_lamp,
  input wire logic out_of_service_lamp,
  input wire logic healthy_lamp,
  input wire logic watchdog_contact,
  input wire logic [fpl_pkg::PROG_LED_N-1:0] prog_red_drive,
  input wire logic [fpl_pkg::PROG_LED_N-1:0] prog_green_drive
);
  import fpl_pkg::*;
  logic any_rec;
  logic [PROG_LED_N-1:0] red_sel;
  logic [PROG_LED_N-1:0] grn_sel;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // red and green ordinals sit interleaved on the bus
  always_comb begin
    for (int i = 0; i < PROG_LED_N; i++) begin
      red_sel[i] = internal_signal_bus[PROG_ORD_BASE + 2 * i];
      grn_sel[i] = internal_signal_bus[PROG_ORD_BASE + 2 * i + 1];
    end
  end
  assign any_rec = new_fault_record | new_event_record | new_maint_record;
  // trip lamp: latch then lamp register, so two edges
  a_trip_lights: assert property (trip_out |-> ##2 trip_lamp)
    else $error("trip lamp not lit");
  a_key_clears: assert property ($rose(clear_key) && !trip_out ##1 !trip_out |=> !trip_lamp)
    else $error("clear key left lamp lit");
  a_input_clears: assert property ($rose(reset_logic_input) && !trip_out ##1 !trip_out
    |=> !trip_lamp)
    else $error("reset input left lamp lit");
  a_record_clears: assert property (fault_record_cleared && !trip_out ##1 !trip_out
    |=> !trip_lamp)
    else $error("record clear left lamp lit");
  // alarm lamp; a new record wins over a clear
  a_alarm_raise: assert property (any_rec |-> ##2 alarm_lamp)
    else $error("alarm lamp not raised");
  a_alarm_off: assert property (alarms_cleared && !any_rec ##1 !any_rec |=> !alarm_lamp)
    else $error("alarm lamp not off");
  // status lamps follow their cause one edge later
  a_oos_on: assert property (protection_unavailable |=> out_of_service_lamp)
    else $error("out of service lamp off");
  a_oos_off: assert property (!protection_unavailable |=> !out_of_service_lamp)
    else $error("out of service lamp on");
  a_healthy_drop: assert property (selftest_fault |=> !healthy_lamp)
    else $error("healthy lamp lit on fault");
  a_watchdog_mirror: assert property (watchdog_contact == healthy_lamp)
    else $error("watchdog differs from healthy");
  a_prog_mirror: assert property (1'b1 |=> prog_red_drive == $past(red_sel)
    && prog_green_drive == $past(grn_sel))
    else $error("programmable drive mismatch");
  c_trip_clear: cover property (trip_lamp ##1 !trip_lamp);
  c_alarm_rise: cover property ($rose(alarm_lamp));
  c_fault: cover property (selftest_fault ##2 !healthy_lamp);
endmodule : fpl_panel_leds_props
bind fpl_panel_leds fpl_panel_leds_props u_props (.*);
`default_nettype wire

// File: verif/fpl_scheme_model.sv
`timescale 1ns/10ps
`default_nettype none
module fpl_scheme_model (
  input wire logic [2*fpl_pkg::PROG_LED_N-1:0] prog_sig,
  input wire logic [fpl_pkg::FKEY_LED_N-1:0] fkey_out,
  output logic [fpl_pkg::BUS_W-1:0] internal_signal_bus
);
  import fpl_pkg::*;
  // scheme drives programmable lamp ordinals and key lamp green ordinals, everything else stays low
  always_comb begin
    internal_signal_bus = '0;
    internal_signal_bus[PROG_ORD_BASE +: 2 * PROG_LED_N] = prog_sig;
    for (int k = 0; k < FKEY_LED_N; k++) begin
      internal_signal_bus[FKEY_ORD_BASE + 2 * k + 1] = fkey_out[k];
    end
  end
endmodule : fpl_scheme_model
`default_nettype wire

// File: verif/fpl_panel_leds_test.sv
`timescale 1ns/10ps
`default_nettype none
module fpl_panel_leds_test;
  import fpl_pkg::*;
  localparam int SRC = 20;
  localparam int FHC = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic trip_out, fault_record_cleared, clear_key, reset_logic_input;
  logic breaker_closed, any_pole_dead, any_start, alarms_read, alarms_cleared;
  logic new_fault_record, new_event_record, new_maint_record;
  logic protection_unavailable, selftest_fault;
  logic [LINK_W-1:0] system_function_link_bits;
  logic [BUS_W-1:0] internal_signal_bus;
  logic [2*PROG_LED_N-1:0] prog_sig;
  logic [FKEY_LED_N-1:0] fkey_out;
  logic trip_lamp, alarm_lamp, out_of_service_lamp, healthy_lamp, watchdog_contact;
  logic [PROG_LED_N-1:0] prog_red_drive, prog_green_drive;
  logic [FKEY_LED_N-1:0] fkey_red_drive, fkey_green_drive;
  logic [1:0] seen;
  int err_total = 0;
  int tests_run = 0;
  // short counts so self-reset and flashing fit the run
  fpl_panel_leds #(.SELF_RESET_CYCLES(SRC), .FLASH_HALF_CYCLES(FHC)) dut (.*);
  fpl_scheme_model model (.*);
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask : chk
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic trip_set();
    trip_out = 1'b1;
    step(1);
    trip_out = 1'b0;
    step(2);
    chk(trip_lamp, 1'b1, "trip lamp");
  endtask : trip_set
  // one clear source pulsed, lamp register settles two edges on
  task automatic src_pulse(input int s);
    {fault_record_cleared, reset_logic_input, clear_key} = 3'(1 << s);
    step(1);
    {fault_record_cleared, reset_logic_input, clear_key} = 3'h0;
    step(2);
  endtask : src_pulse
  task automatic watch_alarm();
    seen = 2'b00;
    repeat (12) begin
      step(1);
      seen = seen | {alarm_lamp === 1'b1, alarm_lamp === 1'b0};
    end
  endtask : watch_alarm
  initial begin
    {trip_out, fault_record_cleared, clear_key, reset_logic_input, breaker_closed} = '0;
    {any_pole_dead, any_start, alarms_read, alarms_cleared, new_fault_record} = '0;
    {new_event_record, new_maint_record, protection_unavailable, selftest_fault} = '0;
    system_function_link_bits = 16'h0000;
    prog_sig = '0;
    fkey_out = '0;
    step(2);
    reset = 1'b0;
    step(2);
    chk(healthy_lamp, 1'b1, "healthy after reset");
    selftest_fault = 1'b1;
    step(2);
    chk(healthy_lamp, 1'b0, "healthy on fault");
    chk(watchdog_contact, 1'b0, "watchdog on fault");
    selftest_fault = 1'b0;
    step(2);
    chk(watchdog_contact, 1'b1, "watchdog healthy");
    protection_unavailable = 1'b1;
    step(2);
    chk(out_of_service_lamp, 1'b1, "oos on");
    protection_unavailable = 1'b0;
    step(2);
    chk(out_of_service_lamp, 1'b0, "oos off");
    // every colour on every programmable lamp: off, red, green, yellow
    for (int i = 0; i < PROG_LED_N; i++) begin
      for (int c = 0; c < 4; c++) begin
        prog_sig = 16'(c << (2 * i));
        step(2);
        chk(prog_red_drive, 16'((c % 2) << i), "red drive");
        chk(prog_green_drive, 16'((c / 2) << i), "green drive");
      end
    end
    for (int k = 0; k < FKEY_LED_N; k++) begin
      fkey_out = 10'(1 << k);
      step(2);
      chk(fkey_green_drive, 16'(1 << k), "key lamp green");
      chk(fkey_red_drive, 16'h0000, "key lamp red");
    end
    // each clear source: refused while tripping, then clears
    for (int s = 0; s < 3; s++) begin
      trip_set();
      trip_out = 1'b1;
      src_pulse(s);
      chk(trip_lamp, 1'b1, "trip beats clear");
      trip_out = 1'b0;
      step(3);
      src_pulse(s);
      chk(trip_lamp, 1'b0, "clear source");
    end
    breaker_closed = 1'b1;
    trip_set();
    step(40);
    chk(trip_lamp, 1'b1, "self-reset disabled");
    system_function_link_bits = 16'h0001;
    step(SRC - 4);
    chk(trip_lamp, 1'b1, "self-reset early");
    step(8);
    chk(trip_lamp, 1'b0, "self-reset done");
    any_pole_dead = 1'b1;
    trip_set();
    step(40);
    chk(trip_lamp, 1'b1, "pole dead holds");
    any_pole_dead = 1'b0;
    step(SRC + 4);
    chk(trip_lamp, 1'b0, "pole dead released");
    trip_set();
    any_start = 1'b1;
    step(1);
    any_start = 1'b0;
    step(40);
    chk(trip_lamp, 1'b1, "start inhibits");
    breaker_closed = 1'b0;
    step(2);
    breaker_closed = 1'b1;
    step(SRC + 4);
    chk(trip_lamp, 1'b0, "reclose clears");
    system_function_link_bits = 16'h0000;
    // each record kind raises a flashing alarm
    for (int k = 0; k < 3; k++) begin
      {new_maint_record, new_event_record, new_fault_record} = 3'(1 << k);
      step(1);
      {new_maint_record, new_event_record, new_fault_record} = 3'h0;
      step(1);
      chk(alarm_lamp, 1'b1, "alarm raised");
      watch_alarm();
      chk(seen, 2'b11, "alarm flashing");
      if (k == 0) begin
        alarms_read = 1'b1;
        step(1);
        alarms_read = 1'b0;
        step(1);
        watch_alarm();
        chk(seen, 2'b10, "alarm steady");
      end
      alarms_cleared = 1'b1;
      step(1);
      alarms_cleared = 1'b0;
      step(1);
      watch_alarm();
      chk(seen, 2'b01, "alarm off");
    end
    final_report();
  end
  // hang guard
  initial begin
    #1000000;
    err_total++;
    final_report();
  end
endmodule : fpl_panel_leds_test
`default_nettype wire
